//--- core/srcs_sequencer.sv
// module: spindle gear range selection and range-change handshake
//
// Operation
// - up to four ranges, each with max speed
// - range change issues function 41 to 44
// - optional residual output: enable, level, period
// - function code out, strobe 50 ms later
// - normal mode: strobe held 100 ms then released
// - residual output starts 200 ms after code
// - extended mode waits for done falling edge
// - normal mode: code 50 ms after strobe
// - extended: strobe 100 ms after done falls, code 150 more
`timescale 1ns/1ps
module srcs_sequencer
    import srcs_pkg::*;
#(
    parameter int MS_TICK_CYCLES = MS_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // register port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    // cabinet link
    input wire logic done_in,
    output logic [7:0] bcd_out,
    output logic strobe_out,
    // residual spindle output
    output logic residual_active_out,
    output logic residual_polarity_out,
    output logic [SPEED_W-1:0] residual_level_out
);

    localparam int TICK_W = $clog2(MS_TICK_CYCLES + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(MS_TICK_CYCLES - 1);

    // ****************************************************************
    // range selection
    // ****************************************************************
    function automatic logic [1:0] pick_range(input srcs_cfg_t c);
        logic [1:0] r;
        r = 2'd3;
        if (c.speed_request <= c.range3_max_speed) r = 2'd2;
        if (c.speed_request <= c.range2_max_speed) r = 2'd1;
        if (c.speed_request <= c.range1_max_speed) r = 2'd0;
        return r;
    endfunction : pick_range

    // ****************************************************************
    // register file
    // ****************************************************************
    srcs_cfg_t cfg_q, cfg_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    srcs_state_t state_q, state_d;
    logic [1:0] range_q, range_d;
    logic [7:0] bcd_q, bcd_d;
    logic strobe_q, strobe_d;
    logic res_act_q, res_act_d;
    logic res_pol_q, res_pol_d;
    logic [SPEED_W-1:0] res_lvl_q, res_lvl_d;
    logic done_q;

    always_comb begin
        cfg_d = cfg_q;
        rdata_d = '0;
        if (wr_in) begin
            case (addr_in)
                REG_RANGE1_MAX: cfg_d.range1_max_speed = wdata_in[SPEED_W-1:0];
                REG_RANGE2_MAX: cfg_d.range2_max_speed = wdata_in[SPEED_W-1:0];
                REG_RANGE3_MAX: cfg_d.range3_max_speed = wdata_in[SPEED_W-1:0];
                REG_RANGE4_MAX: cfg_d.range4_max_speed = wdata_in[SPEED_W-1:0];
                REG_CONTROL: begin
                    cfg_d.residual_output_enable = wdata_in[CTL_RES_EN];
                    cfg_d.extended_handshake_mode = wdata_in[CTL_EXT_HS];
                end
                REG_RES_LEVEL:
                    cfg_d.residual_output_level = wdata_in[SPEED_W-1:0];
                REG_RES_PERIOD:
                    cfg_d.residual_output_period = wdata_in[SPEED_W-1:0];
                REG_SPEED: cfg_d.speed_request = wdata_in[SPEED_W-1:0];
                default: ;
            endcase
        end
        if (rd_in) begin
            case (addr_in)
                REG_RANGE1_MAX: rdata_d[SPEED_W-1:0] = cfg_q.range1_max_speed;
                REG_RANGE2_MAX: rdata_d[SPEED_W-1:0] = cfg_q.range2_max_speed;
                REG_RANGE3_MAX: rdata_d[SPEED_W-1:0] = cfg_q.range3_max_speed;
                REG_RANGE4_MAX: rdata_d[SPEED_W-1:0] = cfg_q.range4_max_speed;
                REG_CONTROL: begin
                    rdata_d[CTL_RES_EN] = cfg_q.residual_output_enable;
                    rdata_d[CTL_EXT_HS] = cfg_q.extended_handshake_mode;
                end
                REG_RES_LEVEL:
                    rdata_d[SPEED_W-1:0] = cfg_q.residual_output_level;
                REG_RES_PERIOD:
                    rdata_d[SPEED_W-1:0] = cfg_q.residual_output_period;
                REG_SPEED: rdata_d[SPEED_W-1:0] = cfg_q.speed_request;
                REG_STATUS: begin
                    rdata_d[STS_RANGE_LO +: 2] = range_q;
                    rdata_d[STS_BUSY] = (state_q != ST_IDLE);
                    rdata_d[STS_STROBE] = strobe_q;
                    rdata_d[STS_RESIDUAL] = res_act_q;
                    rdata_d[STS_DONE] = done_q;
                end
                default: ; // unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cfg_q <= '{RANGE_MAX_RST, RANGE_MAX_RST, RANGE_MAX_RST,
                       RANGE_MAX_RST, 1'b0, 1'b0, RES_LEVEL_RST,
                       RES_PERIOD_RST, SPEED_RST};
            rdata_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************************************
    // done synchroniser and millisecond tick
    // ****************************************************************
    logic done_s1_q, done_s2_q, done_s3_q, done_d;
    logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;

    always_comb begin
        // change accepted only once stages two and three agree
        done_d = (done_s2_q == done_s3_q) ? done_s3_q : done_q;
        tick_d = (tick_cnt_q == TICK_LAST);
        tick_cnt_d = tick_d ? '0 : tick_cnt_q + TICK_W'(1);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            done_s1_q <= 1'b1;
            done_s2_q <= 1'b1;
            done_s3_q <= 1'b1;
            done_q <= 1'b1;
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            done_s1_q <= done_in;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
            done_q <= done_d;
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
        end
    end

    // ****************************************************************
    // handshake sequencer
    // ****************************************************************
    logic [MS_CNT_W-1:0] ms_q, ms_d;
    logic [MS_CNT_W-1:0] elapsed_q, elapsed_d;
    logic [SPEED_W-1:0] per_q, per_d;
    logic done_prev_q;
    logic seen_low_q, seen_low_d;
    logic [1:0] target;
    logic ms_hit;

    always_comb begin
        target = pick_range(cfg_q);
        state_d = state_q;
        range_d = range_q;
        bcd_d = bcd_q;
        strobe_d = strobe_q;
        ms_d = ms_q;
        elapsed_d = elapsed_q;
        seen_low_d = seen_low_q | ~done_q;
        ms_hit = 1'b0;
        if (tick_q && state_q != ST_IDLE) begin
            ms_d = ms_q + MS_CNT_W'(1);
            ms_hit = 1'b1;
            if (elapsed_q != '1) elapsed_d = elapsed_q + MS_CNT_W'(1);
        end
        case (state_q)
            ST_IDLE: begin
                if (target != range_q) begin
                    range_d = target;
                    bcd_d = RANGE_FUNC_BASE + {6'd0, target};
                    state_d = ST_LEAD;
                    ms_d = '0;
                    elapsed_d = '0;
                    seen_low_d = 1'b0;
                end
            end
            ST_LEAD: begin
                if (ms_hit && ms_q == MS_CNT_W'(LEAD_MS - 1)) begin
                    strobe_d = 1'b1;
                    ms_d = '0;
                    state_d = cfg_q.extended_handshake_mode ?
                              ST_WAIT_FALL : ST_STROBE;
                end
            end
            ST_WAIT_FALL: begin
                // strobe stays up until the cabinet answers
                ms_d = '0;
                if (done_prev_q && !done_q) state_d = ST_STROBE;
            end
            ST_STROBE: begin
                if (ms_hit && ms_q == MS_CNT_W'(STROBE_MS - 1)) begin
                    strobe_d = 1'b0;
                    ms_d = '0;
                    state_d = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (ms_hit && ((!cfg_q.extended_handshake_mode &&
                     ms_q == MS_CNT_W'(TAIL_NORMAL_MS - 1)) ||
                    (cfg_q.extended_handshake_mode &&
                     ms_q == MS_CNT_W'(TAIL_EXT_MS - 1)))) begin
                    bcd_d = '0;
                    // a cabinet that never dropped done is not waited on
                    state_d = seen_low_d ? ST_WAIT_DONE : ST_IDLE;
                end
            end
            ST_WAIT_DONE: begin
                if (done_q) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // residual output: oscillates from 200 ms after the code until the sequencer returns to idle
    always_comb begin
        res_act_d = 1'b0;
        res_pol_d = 1'b0;
        res_lvl_d = '0;
        per_d = '0;
        if (state_q != ST_IDLE && cfg_q.residual_output_enable &&
            elapsed_q >= MS_CNT_W'(RESIDUAL_START_MS)) begin
            res_act_d = 1'b1;
            res_lvl_d = cfg_q.residual_output_level;
            res_pol_d = res_pol_q;
            per_d = per_q;
            if (tick_q) begin
                per_d = per_q + SPEED_W'(1);
                // a zero period holds a steady level
                if (cfg_q.residual_output_period != '0 &&
                    per_d >= cfg_q.residual_output_period) begin
                    per_d = '0;
                    res_pol_d = ~res_pol_q;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            range_q <= 2'd0;
            bcd_q <= 8'h00;
            strobe_q <= 1'b0;
            ms_q <= '0;
            elapsed_q <= '0;
            seen_low_q <= 1'b0;
            done_prev_q <= 1'b1;
            res_act_q <= 1'b0;
            res_pol_q <= 1'b0;
            res_lvl_q <= '0;
            per_q <= '0;
        end else begin
            state_q <= state_d;
            range_q <= range_d;
            bcd_q <= bcd_d;
            strobe_q <= strobe_d;
            ms_q <= ms_d;
            elapsed_q <= elapsed_d;
            seen_low_q <= seen_low_d;
            done_prev_q <= done_q;
            res_act_q <= res_act_d;
            res_pol_q <= res_pol_d;
            res_lvl_q <= res_lvl_d;
            per_q <= per_d;
        end
    end

    assign rdata_out = rdata_q;
    assign bcd_out = bcd_q;
    assign strobe_out = strobe_q;
    assign residual_active_out = res_act_q;
    assign residual_polarity_out = res_pol_q;
    assign residual_level_out = res_lvl_q;

endmodule : srcs_sequencer

//--- core/srcs_pkg.sv
// package: constants and types of the spindle range change sequencer
package srcs_pkg;

    // ****************************************************************
    // bus and register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SPEED_W = 16;
    localparam logic [ADDR_W-1:0] REG_RANGE1_MAX = 8'h00;
    localparam logic [ADDR_W-1:0] REG_RANGE2_MAX = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RANGE3_MAX = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RANGE4_MAX = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h10;
    localparam logic [ADDR_W-1:0] REG_RES_LEVEL = 8'h14;
    localparam logic [ADDR_W-1:0] REG_RES_PERIOD = 8'h18;
    localparam logic [ADDR_W-1:0] REG_SPEED = 8'h1C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h20;

    // control and status bit positions
    localparam int CTL_RES_EN = 0;
    localparam int CTL_EXT_HS = 1;
    localparam int STS_RANGE_LO = 0;
    localparam int STS_BUSY = 2;
    localparam int STS_STROBE = 3;
    localparam int STS_RESIDUAL = 4;
    localparam int STS_DONE = 5;

    // reset values
    localparam logic [SPEED_W-1:0] RANGE_MAX_RST = 16'hFFFF;
    localparam logic [SPEED_W-1:0] RES_LEVEL_RST = 16'h0000;
    localparam logic [SPEED_W-1:0] RES_PERIOD_RST = 16'h0064;
    localparam logic [SPEED_W-1:0] SPEED_RST = 16'h0000;

    // range-select function code base: range index 0..3 gives 41..44
    localparam logic [7:0] RANGE_FUNC_BASE = 8'h41;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MS_PS = 1_000_000_000;
    localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
    localparam int LEAD_MS = 50;
    localparam int STROBE_MS = 100;
    localparam int TAIL_NORMAL_MS = 50;
    localparam int TAIL_EXT_MS = 150;
    localparam int RESIDUAL_START_MS = 200;
    localparam int MS_CNT_W = 8;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEAD,
        ST_WAIT_FALL,
        ST_STROBE,
        ST_TAIL,
        ST_WAIT_DONE
    } srcs_state_t;

    typedef struct packed {
        logic [SPEED_W-1:0] range1_max_speed;
        logic [SPEED_W-1:0] range2_max_speed;
        logic [SPEED_W-1:0] range3_max_speed;
        logic [SPEED_W-1:0] range4_max_speed;
        logic residual_output_enable;
        logic extended_handshake_mode;
        logic [SPEED_W-1:0] residual_output_level;
        logic [SPEED_W-1:0] residual_output_period;
        logic [SPEED_W-1:0] speed_request;
    } srcs_cfg_t;

endpackage : srcs_pkg

//--- verification/srcs_assertions.sv
// checker: port code, read and timing assertions for the range change sequencer
`timescale 1ns/1ps
module srcs_assertions
    import srcs_pkg::*;
#(
    parameter int MS_TICK_CYCLES = 250000
) (
    // clock, reset and register port
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    // cabinet link and residual output
    input wire logic done_in,
    input wire logic [7:0] bcd_out,
    input wire logic strobe_out,
    input wire logic residual_active_out,
    input wire logic residual_polarity_out,
    input wire logic [SPEED_W-1:0] residual_level_out
);
    localparam int T = MS_TICK_CYCLES;
    logic ext_q;
    int bcd_q, str_q, off_q, seq_q;
    // cycle counters; mode mirrored from control writes
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            ext_q <= 1'b0;
            bcd_q <= 0;
            str_q <= 0;
            off_q <= 0;
            seq_q <= 0;
        end else begin
            if (wr_in && addr_in == REG_CONTROL) ext_q <= wdata_in[CTL_EXT_HS];
            bcd_q <= (bcd_out == 8'h00) ? 0 : bcd_q + 1;
            str_q <= strobe_out ? str_q + 1 : 0;
            off_q <= strobe_out ? 0 : off_q + 1;
            seq_q <= (bcd_out != 8'h00 && bcd_q == 0) ? 0 : seq_q + 1;
        end
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence s_str_on; $rose(strobe_out); endsequence
    sequence s_str_off; $fell(strobe_out); endsequence
    sequence s_code_off; $past(bcd_out) != 8'h00 && bcd_out == 8'h00;
    endsequence
    property p_code;
        bcd_out == 8'h00 || (bcd_out >= 8'h41 && bcd_out <= 8'h44);
    endproperty
    a_code: assert property (p_code)
        else $error("function code out of range");
    property p_stable;
        (bcd_out != 8'h00) ##1 (bcd_out != 8'h00) |-> $stable(bcd_out);
    endproperty
    a_stable: assert property (p_stable)
        else $error("function code changed mid sequence");
    property p_strobe_code; strobe_out |-> bcd_out != 8'h00; endproperty
    a_strobe_code: assert property (p_strobe_code)
        else $error("strobe without function code");
    property p_lead; s_str_on |-> bcd_q >= 49*T-3 && bcd_q <= 50*T+3;
    endproperty
    a_lead: assert property (p_lead)
        else $error("strobe lead time wrong");
    property p_width;
        s_str_off |-> str_q >= 100*T-3 && (ext_q || str_q <= 100*T+3);
    endproperty
    a_width: assert property (p_width)
        else $error("strobe width wrong");
    property p_tail;
        s_code_off |-> ext_q ? (off_q >= 150*T-3 && off_q <= 150*T+3)
            : (off_q >= 50*T-3 && off_q <= 50*T+3);
    endproperty
    a_tail: assert property (p_tail)
        else $error("code tail after strobe wrong");
    property p_res_start; $rose(residual_active_out) |-> seq_q >= 199*T-3;
    endproperty
    a_res_start: assert property (p_res_start)
        else $error("residual output started early");
    property p_res_level;
        !residual_active_out |-> residual_level_out == 16'h0000;
    endproperty
    a_res_level: assert property (p_res_level)
        else $error("residual level while inactive");
    property p_read; rdata_out != 32'h0000_0000 |-> $past(rd_in); endproperty
    a_read: assert property (p_read)
        else $error("read data without read strobe");
endmodule : srcs_assertions

//--- verification/srcs_cabinet_model.sv
// partner: electrical cabinet executing the range-select function
`timescale 1ns/1ps
module srcs_cabinet_model (
    // clock, strobe from the sequencer, and busy length
    input wire logic clock_in,
    input wire logic strobe_in,
    input wire logic [15:0] busy_in,
    // done back to the sequencer
    output logic done_out
);
    // busy_in sets a prompt or slow gear change
    initial begin
        done_out = 1'b1;
        forever begin
            @(posedge strobe_in);
            repeat (20) @(posedge clock_in);
            done_out <= 1'b0;
            repeat (busy_in) @(posedge clock_in);
            done_out <= 1'b1;
        end
    end
endmodule : srcs_cabinet_model

//--- verification/spindle_range_change_sequencer_test.sv
// testbench: range selection and cabinet handshake timing
`timescale 1ns/1ps
module spindle_range_change_sequencer_test;
    import srcs_pkg::*;
    // short millisecond keeps the run small
    localparam int T = 10;
    typedef struct {logic [15:0] spd; logic [7:0] code; int idx;} srcs_row_t;
    srcs_row_t rows[7] = '{'{16'h0096, 8'h42, 1}, '{16'h0190, 8'h44, 3},
        '{16'h0032, 8'h41, 0}, '{16'h00FA, 8'h43, 2}, '{16'h01F4, 8'h44, 3},
        '{16'h012D, 8'h00, 3}, '{16'h0000, 8'h41, 0}};
    logic clock_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, done_in;
    logic [7:0] addr_in = 0, bcd_out;
    logic [31:0] wdata_in = 0, rdata_out, rd_v;
    logic strobe_out, residual_active_out, residual_polarity_out, p;
    logic [15:0] residual_level_out, busy = 16'h0032;
    logic [4:0] ev;
    int errors = 0, tests_run = 0, cyc = 0, n, t;
    assign ev = {residual_active_out === 1'b0, residual_active_out === 1'b1,
        bcd_out === 8'h00, strobe_out === 1'b0, strobe_out === 1'b1};
    srcs_sequencer #(.MS_TICK_CYCLES(T)) DUT (.clock_in(clock_in),
        .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .done_in(done_in), .bcd_out(bcd_out), .strobe_out(strobe_out),
        .residual_active_out(residual_active_out),
        .residual_polarity_out(residual_polarity_out),
        .residual_level_out(residual_level_out));
    srcs_cabinet_model cab (.clock_in(clock_in), .strobe_in(strobe_out),
        .busy_in(busy), .done_out(done_in));
    initial forever #2 clock_in = ~clock_in;
    task automatic conclude;
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input string s, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            $display("unexpected %s: expected %h seen %h", s, e, g);
            errors++;
        end
    endtask : chk
    task automatic rng(input string s, input int lo, hi);
        chk(s, 32'h1, {31'h0, n >= lo && n <= hi});
    endtask : rng
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= {16'h0000, d};
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1;
        rd_v = rdata_out;
    endtask : rd
    // counts cycles until the chosen event, bounded
    task automatic wt(input int k);
        n = 0;
        while (!ev[k] && n < 20000) begin
            @(posedge clock_in);
            #1;
            n++;
        end
        chk("event", 32'h1, {31'h0, ev[k]});
    endtask : wt
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        chk("bcd", 32'h0, {24'h0, bcd_out});
        rd(REG_RANGE1_MAX);
        chk("range1", 32'h0000_FFFF, rd_v);
        rd(REG_RES_PERIOD);
        chk("period", 32'h0000_0064, rd_v);
        rd(8'h40);
        chk("unmapped", 32'h0, rd_v);
        rd(REG_STATUS);
        chk("status", 32'h0000_0020, rd_v);
        wr(REG_RANGE1_MAX, 16'h0064);
        wr(REG_RANGE2_MAX, 16'h00C8);
        wr(REG_RANGE3_MAX, 16'h012C);
        wr(REG_RANGE4_MAX, 16'h0190);
        foreach (rows[i]) begin
            wr(REG_SPEED, rows[i].spd);
            repeat (2) @(posedge clock_in);
            #1;
            chk("code", {24'h0, rows[i].code}, {24'h0, bcd_out});
            if (rows[i].code != 8'h00) begin
                wt(0);
                rng("lead", 49*T-4, 50*T+4);
                wt(1);
                rng("strobe", 100*T-2, 100*T+2);
                wt(2);
                rng("tail", 50*T-2, 50*T+2);
            end
            repeat (4) @(posedge clock_in);
            rd(REG_STATUS);
            chk("status", 32'h0000_0020 | rows[i].idx, rd_v);
        end
        // slow cabinet, extended mode, residual with period 3
        busy = 16'h0BB8;
        wr(REG_RES_LEVEL, 16'h1234);
        wr(REG_RES_PERIOD, 16'h0003);
        wr(REG_CONTROL, 16'h0003);
        wr(REG_SPEED, 16'h00FA);
        wt(0);
        wt(1);
        rng("ext strobe", 99*T+20, 100*T+30);
        wt(3);
        #5;
        chk("level", 32'h0000_1234, {16'h0, residual_level_out});
        p = residual_polarity_out;
        t = 0;
        repeat (12 * T) begin
            @(posedge clock_in);
            #1;
            if (residual_polarity_out !== p) t++;
            p = residual_polarity_out;
        end
        n = t;
        rng("toggles", 3, 5);
        wt(2);
        rd(REG_STATUS);
        chk("busy", 32'h1, {31'h0, rd_v[STS_BUSY]});
        wt(4);
        repeat (4) @(posedge clock_in);
        rd(REG_STATUS);
        chk("idle", 32'h0000_0022, rd_v);
        // normal mode, slow cabinet; a zero period holds the phase
        wr(REG_RES_PERIOD, 16'h0000);
        wr(REG_CONTROL, 16'h0001);
        rd(REG_CONTROL);
        chk("control", 32'h0000_0001, rd_v);
        wr(REG_SPEED, 16'h0032);
        wt(3);
        t = 0;
        repeat (12 * T) begin
            @(posedge clock_in);
            #1;
            if (residual_polarity_out !== 1'b0 || !ev[3]) t++;
        end
        n = t;
        rng("steady", 0, 0);
        rd(REG_STATUS);
        chk("residual", 32'h0000_0014, rd_v & 32'h0000_0014);
        wt(4);
        // reset in mid-sequence clears the outputs and the setup
        wr(REG_SPEED, 16'h01F4);
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b1;
        #1;
        chk("lead code", 32'h0000_0044, {24'h0, bcd_out});
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        #1;
        chk("reset code", 32'h0, {24'h0, bcd_out});
        rd(REG_STATUS);
        chk("reset status", 32'h0000_0020, rd_v);
        rd(REG_RANGE4_MAX);
        chk("reset range4", 32'h0000_FFFF, rd_v);
        conclude();
    end
endmodule : spindle_range_change_sequencer_test
bind srcs_sequencer srcs_assertions #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_chk (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .done_in(done_in), .bcd_out(bcd_out),
    .strobe_out(strobe_out), .residual_active_out(residual_active_out),
    .residual_polarity_out(residual_polarity_out),
    .residual_level_out(residual_level_out));
